// ---- src/swc_pkg.sv ----
// Purpose: shared constants and types of the single-wire bus controller
// Assumes: 40 MHz system clock, timing counted in 250 ns ticks
// Notes:   standard and fast timing sets, command codes, crc constants
package swc_pkg;

    localparam int unsigned CLK_NS   = 25;
    localparam int unsigned TICK_NS  = 250;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
    localparam int unsigned TW       = 12;

    // standard speed, in ns
    localparam int unsigned STD_RSTL_NS  = 480000;
    localparam int unsigned STD_RSTH_NS  = 480000;
    localparam int unsigned STD_PSMP_NS  = 70000;
    localparam int unsigned STD_W0L_NS   = 60000;
    localparam int unsigned STD_W1L_NS   = 6000;
    localparam int unsigned STD_RL_NS    = 6000;
    localparam int unsigned STD_MSR_NS   = 14000;
    localparam int unsigned STD_SLOT_NS  = 65000;
    localparam int unsigned STD_REC_NS   = 5000;
    // fast speed, in ns
    localparam int unsigned FST_RSTL_NS  = 56000;
    localparam int unsigned FST_RSTL_MAX_NS = 80000;
    localparam int unsigned FST_RSTH_NS  = 48000;
    localparam int unsigned FST_PSMP_NS  = 8000;
    localparam int unsigned FST_W0L_NS   = 8000;
    localparam int unsigned FST_W1L_NS   = 1000;
    localparam int unsigned FST_RL_NS    = 1000;
    localparam int unsigned FST_MSR_NS   = 2000;
    localparam int unsigned FST_SLOT_NS  = 12000;
    localparam int unsigned FST_REC_NS   = 2000;

    // least times round up, longest times round down
    localparam logic [TW-1:0] STD_RSTH_T = TW'((STD_RSTH_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [TW-1:0] STD_PSMP_T = TW'(STD_PSMP_NS / TICK_NS);
    localparam logic [TW-1:0] STD_W0L_T  = TW'((STD_W0L_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [TW-1:0] STD_W1L_T  = TW'(STD_W1L_NS / TICK_NS);
    localparam logic [TW-1:0] STD_RL_T   = TW'(STD_RL_NS / TICK_NS);
    localparam logic [TW-1:0] STD_MSR_T  = TW'(STD_MSR_NS / TICK_NS);
    localparam logic [TW-1:0] STD_END_T  =
        TW'((STD_SLOT_NS + STD_REC_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [TW-1:0] FST_RSTH_T = TW'((FST_RSTH_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [TW-1:0] FST_PSMP_T = TW'(FST_PSMP_NS / TICK_NS);
    localparam logic [TW-1:0] FST_W0L_T  = TW'((FST_W0L_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [TW-1:0] FST_W1L_T  = TW'(FST_W1L_NS / TICK_NS);
    localparam logic [TW-1:0] FST_RL_T   = TW'(FST_RL_NS / TICK_NS);
    localparam logic [TW-1:0] FST_MSR_T  = TW'(FST_MSR_NS / TICK_NS);
    localparam logic [TW-1:0] FST_END_T  =
        TW'((FST_SLOT_NS + FST_REC_NS + TICK_NS - 1) / TICK_NS);

    localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE   = 16'hb001;
    localparam logic [15:0] CRC_INIT      = 16'h0000;

    typedef enum logic [2:0] {
        CMD_RESET     = 3'h1,
        CMD_RESET_STD = 3'h2,
        CMD_WRITE     = 3'h3,
        CMD_READ      = 3'h4,
        CMD_SET_FAST  = 3'h5,
        CMD_CRC_CLEAR = 3'h6
    } swc_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RST_LOW   = 3'b001,
        ST_RST_HIGH  = 3'b010,
        ST_SLOT_LOW  = 3'b011,
        ST_SLOT_REST = 3'b100
    } swc_state_type;

endpackage

// ---- src/swc_crc16.sv ----
// Purpose: bitwise crc-16 over the bits carried on the line, lsb first
// Assumes: one bit per bit_en pulse
// Notes:   good_q is high when the running value equals the residue
`timescale 1ns/100ps
module swc_crc16
    import swc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        bit_en,
    input  wire logic        bit_val,
    output logic      [15:0] crc_q,
    output logic             good_q
);

    logic [15:0] crc_d;

    always_comb begin
        crc_d = crc_q >> 1;
        if (crc_q[0] ^ bit_val) begin
            crc_d = crc_d ^ CRC_POLY_REFL;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q  <= CRC_INIT;
            good_q <= 1'b0;
        end else if (clear) begin
            crc_q  <= CRC_INIT;
            good_q <= 1'b0;
        end else if (bit_en) begin
            crc_q  <= crc_d;
            good_q <= (crc_d == CRC_RESIDUE);
        end
    end

endmodule

// ---- src/swc_host.sv ----
// Purpose: bus controller for a single-wire open-drain peripheral link
// Assumes: line_i is synchronous to sys_clk; external pull-up holds line high
// Notes:   byte-level command port; line_o is always low, line_oe pulls the line
//
// Function
// - order: reset, addressing, function command, data
// - crc-16 runs over every transferred bit
// - idle leaves the line released high
// - long low means reset: speed thresholds
// - standard and fast speeds supported
// - controller starts every falling edge
// - reset low extended by fall time
// - sample presence at presence sample time
// - reset-high window covers presence plus recovery
// - reset-high window 480 / 48 us
// - one bit per time slot
// - write one released before max low
// - write zero held past min low; the first slot of a byte may end up to one tick short of it
// - recovery interval before next slot
// - read slot starts like write one
// - sample read bit near window end
// - wait full slot after sampling
`timescale 1ns/100ps
module swc_host
    import swc_pkg::*;
#(
    parameter int unsigned FALL_TIME_NS = 0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_code,
    input  wire logic [7:0]  cmd_data,
    output logic             ready_q,
    output logic             done_q,
    output logic             error_q,
    output logic      [7:0]  rd_data_q,
    output logic             presence_q,
    output logic             fast_q,
    output logic      [15:0] crc_q,
    output logic             crc_good_q,
    input  wire logic        line_i,
    output logic             line_o_q,
    output logic             line_oe_q
);

    localparam logic [TW-1:0] STD_RSTL_T =
        TW'((STD_RSTL_NS + FALL_TIME_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [TW-1:0] FST_RSTL_T =
        TW'((FST_RSTL_NS + FALL_TIME_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

    swc_state_type   st_q;
    logic [7:0]      div_q;
    logic            tick;
    logic [TW-1:0]   tcnt_q;
    logic [7:0]      sh_q;
    logic [2:0]      idx_q;
    logic            rd_q;
    logic            linked_q;
    logic            crc_en_q;
    logic            crc_bit_q;
    logic            crc_clr_q;
    logic            take;
    logic            data_cmd;
    logic [TW-1:0]   rstl_t;
    logic [TW-1:0]   rsth_t;
    logic [TW-1:0]   psmp_t;
    logic [TW-1:0]   low_t;
    logic [TW-1:0]   msr_t;
    logic [TW-1:0]   end_t;

    assign take     = cmd_valid && ready_q;
    assign data_cmd = (cmd_code == CMD_WRITE) || (cmd_code == CMD_READ);

    // speed-dependent limits; slow set unless fast chosen
    assign rstl_t = fast_q ? FST_RSTL_T : STD_RSTL_T;
    assign rsth_t = fast_q ? FST_RSTH_T : STD_RSTH_T;
    assign psmp_t = fast_q ? FST_PSMP_T : STD_PSMP_T;
    assign msr_t  = fast_q ? FST_MSR_T  : STD_MSR_T;
    assign end_t  = fast_q ? FST_END_T  : STD_END_T;
    always_comb begin
        if (rd_q) begin
            low_t = fast_q ? FST_RL_T : STD_RL_T;
        end else if (sh_q[0]) begin
            low_t = fast_q ? FST_W1L_T : STD_W1L_T;
        end else begin
            low_t = fast_q ? FST_W0L_T : STD_W0L_T;
        end
    end

    // tick divider, 250 ns
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else if (div_q == TICK_LAST) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign tick = (div_q == TICK_LAST);

    // speed selection: a standard reset always drops fast mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_q <= 1'b0;
        end else if (take && cmd_code == CMD_RESET_STD) begin
            fast_q <= 1'b0;
        end else if (take && cmd_code == CMD_SET_FAST) begin
            fast_q <= 1'b1;
        end
    end

    // line sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= ST_IDLE;
            tcnt_q     <= '0;
            line_oe_q  <= 1'b0;
            line_o_q   <= 1'b0;
            sh_q       <= 8'h00;
            idx_q      <= 3'h0;
            rd_q       <= 1'b0;
            presence_q <= 1'b0;
            linked_q   <= 1'b0;
            crc_en_q   <= 1'b0;
            crc_bit_q  <= 1'b0;
            crc_clr_q  <= 1'b0;
            ready_q    <= 1'b1;
            done_q     <= 1'b0;
            error_q    <= 1'b0;
            rd_data_q  <= 8'h00;
        end else begin
            line_o_q  <= 1'b0;
            crc_en_q  <= 1'b0;
            crc_clr_q <= 1'b0;
            done_q    <= 1'b0;
            error_q   <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    line_oe_q <= 1'b0;
                    if (take) begin
                        tcnt_q <= '0;
                        case (cmd_code)
                            CMD_RESET, CMD_RESET_STD: begin
                                st_q       <= ST_RST_LOW;
                                line_oe_q  <= 1'b1;
                                ready_q    <= 1'b0;
                                presence_q <= 1'b0;
                                linked_q   <= 1'b0;
                            end
                            CMD_WRITE, CMD_READ: begin
                                if (linked_q) begin
                                    st_q      <= ST_SLOT_LOW;
                                    line_oe_q <= 1'b1;
                                    ready_q   <= 1'b0;
                                    rd_q      <= (cmd_code == CMD_READ);
                                    sh_q      <= (cmd_code == CMD_READ) ? 8'hff : cmd_data;
                                    idx_q     <= 3'h0;
                                end else begin
                                    done_q  <= 1'b1;
                                    error_q <= 1'b1;
                                end
                            end
                            CMD_CRC_CLEAR: begin
                                crc_clr_q <= 1'b1;
                                done_q    <= 1'b1;
                            end
                            CMD_SET_FAST: begin
                                done_q <= 1'b1;
                            end
                            default: begin
                                done_q  <= 1'b1;
                                error_q <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_RST_LOW: begin
                    if (tick) begin
                        tcnt_q <= tcnt_q + 1'b1;
                        if (tcnt_q == rstl_t - 1'b1) begin
                            st_q      <= ST_RST_HIGH;
                            line_oe_q <= 1'b0;
                            tcnt_q    <= '0;
                        end
                    end
                end
                ST_RST_HIGH: begin
                    if (tick) begin
                        tcnt_q <= tcnt_q + 1'b1;
                        if (tcnt_q == psmp_t - 1'b1) begin
                            presence_q <= !line_i;
                            linked_q   <= !line_i;
                        end
                        if (tcnt_q == rsth_t - 1'b1) begin
                            st_q    <= ST_IDLE;
                            ready_q <= 1'b1;
                            done_q  <= 1'b1;
                            error_q <= !linked_q;
                        end
                    end
                end
                ST_SLOT_LOW: begin
                    if (tick) begin
                        tcnt_q <= tcnt_q + 1'b1;
                        if (tcnt_q == low_t - 1'b1) begin
                            st_q      <= ST_SLOT_REST;
                            line_oe_q <= 1'b0;
                        end
                    end
                end
                ST_SLOT_REST: begin
                    if (tick) begin
                        tcnt_q <= tcnt_q + 1'b1;
                        if (rd_q && tcnt_q == msr_t - 1'b1) begin
                            sh_q[0] <= line_i;
                        end
                        if (tcnt_q == end_t - 1'b1) begin
                            crc_en_q  <= 1'b1;
                            crc_bit_q <= sh_q[0];
                            sh_q      <= {sh_q[0], sh_q[7:1]};
                            tcnt_q    <= '0;
                            if (idx_q == 3'h7) begin
                                st_q      <= ST_IDLE;
                                ready_q   <= 1'b1;
                                done_q    <= 1'b1;
                                rd_data_q <= {sh_q[0], sh_q[7:1]};
                            end else begin
                                idx_q     <= idx_q + 3'h1;
                                st_q      <= ST_SLOT_LOW;
                                line_oe_q <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    st_q      <= ST_IDLE;
                    line_oe_q <= 1'b0;
                    ready_q   <= 1'b1;
                end
            endcase
        end
    end

    swc_crc16 u_crc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (crc_clr_q),
        .bit_en  (crc_en_q),
        .bit_val (crc_bit_q),
        .crc_q   (crc_q),
        .good_q  (crc_good_q)
    );

    // helper: length of the current low drive in clocks
    logic [15:0] low_cnt_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= 16'h0000;
        end else if (!line_oe_q) begin
            low_cnt_q <= 16'h0000;
        end else begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    localparam int STD_RSTL_MIN_CYC = (STD_RSTL_NS / TICK_NS - 1) * TICK_CYC;
    localparam int FST_RSTL_MAX_CYC = FST_RSTL_MAX_NS / CLK_NS;
    localparam int STD_W1L_MAX_CYC  = STD_W1L_NS / CLK_NS;
    localparam int STD_W0L_MIN_CYC  = (STD_W0L_NS / TICK_NS - 1) * TICK_CYC;

    a_idle_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_IDLE && !take |=> !line_oe_q)
        else $error("line driven while idle");
    a_edge_owner: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(line_oe_q) |-> st_q == ST_RST_LOW || st_q == ST_SLOT_LOW)
        else $error("falling edge outside reset or slot");
    a_std_reset_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(line_oe_q) && st_q == ST_RST_HIGH && !fast_q |-> low_cnt_q >= STD_RSTL_MIN_CYC)
        else $error("standard reset low too short");
    a_fast_reset_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(line_oe_q) && st_q == ST_RST_HIGH && fast_q |-> low_cnt_q <= FST_RSTL_MAX_CYC)
        else $error("fast reset low too long");
    a_write_one_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(line_oe_q) && st_q == ST_SLOT_REST && !fast_q && (rd_q || sh_q[0])
        |-> low_cnt_q <= STD_W1L_MAX_CYC)
        else $error("write one low too long");
    a_write_zero_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(line_oe_q) && st_q == ST_SLOT_REST && !fast_q && !rd_q && !sh_q[0]
        |-> low_cnt_q >= STD_W0L_MIN_CYC)
        else $error("write zero low too short");
    a_unlinked_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take && data_cmd && !linked_q |=> error_q && done_q && st_q == ST_IDLE)
        else $error("data command accepted before presence");
    a_slot_recovery: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(line_oe_q) && st_q == ST_SLOT_REST && fast_q |-> !line_oe_q [*8])
        else $error("next slot began before recovery");
    a_crc_per_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_SLOT_REST && tick && tcnt_q == end_t - 1'b1 |=> crc_en_q)
        else $error("slot end without crc update");

    c_reset_present: cover property (@(posedge sys_clk) disable iff (!rst_n)
        done_q && presence_q && !error_q);
    c_byte_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_SLOT_REST && !rd_q && idx_q == 3'h7 ##1 done_q);
    c_byte_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_SLOT_REST && rd_q && idx_q == 3'h7 ##1 done_q);
    c_fast_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
        fast_q && $fell(line_oe_q) && st_q == ST_RST_HIGH);

endmodule

// ---- bench/swc_dev_model.sv ----
// Purpose: behavioural peripheral on the far side of the single-wire link
// Assumes: line is the wired level with pull-up; times in ns
// Notes:   rom commands are not decoded, so go_fast and reply_en stand in for them
`timescale 1ns/100ps
module swc_dev_model (
    input  wire logic       line,
    input  wire logic       present,
    input  wire logic       go_fast,
    input  wire logic       reply_en,
    input  wire logic       slow_reply,
    input  wire logic [7:0] tx_byte,
    output logic            pull,
    output logic            od,
    output logic      [7:0] rx_byte,
    output int              rec_err,
    output int              falls,
    output longint          last_low
);
    realtime t_fall = 0;
    realtime t_rise = 0;
    realtime low    = 0;
    int      idx    = 0;
    int      bits   = 0;
    logic    go_seen = 1'b0;

    // odd 3 ns offsets keep the model's own edges off the clock edges
    initial begin
        pull     = 1'b0;
        od       = 1'b0;
        rx_byte  = 8'h00;
        rec_err  = 0;
        falls    = 0;
        last_low = 0;
        forever begin
            // only the controller starts a fall; presence runs inside the delays below
            @(negedge line);
            t_fall = $realtime;
            falls++;
            // a rising go_fast stands for the speed-change addressing byte
            if (go_fast && !go_seen)
                od = 1'b1;
            go_seen = go_fast;
            if (bits > 0 && t_fall - t_rise < (od ? 2000 : 5000))
                rec_err++;
            if (reply_en && present && !tx_byte[idx]) begin
                pull = 1'b1;
                #(od ? 4003 : 30003);
                pull = 1'b0;
            end
            wait (line === 1'b1);
            t_rise = $realtime;
            low    = t_rise - t_fall;
            if (low >= (od ? 16000 : 120000)) begin
                last_low = longint'(low);
                // a mid-length fast reset leaves speed open: model picks standard
                if (low > 80000)
                    od = 1'b0;
                bits = 0;
                idx  = 0;
                if (present) begin
                    #(od ? (slow_reply ? 5003 : 2003) : (slow_reply ? 50003 : 15003));
                    pull = 1'b1;
                    #(od ? 10000 : 120000);
                    pull   = 1'b0;
                    t_rise = $realtime;
                end
            end else if (reply_en) begin
                idx = (idx + 1) % 8;
                bits++;
            end else begin
                rx_byte = {low < (od ? 2000 : 15000), rx_byte[7:1]};
                bits++;
            end
        end
    end
endmodule

// ---- bench/swc_host_test.sv ----
// Purpose: self-checking bench for the single-wire bus controller
// Assumes: peripheral model on the wired line, fall time of 2 us
// Notes:   fast speed carries most traffic to keep the run short
`timescale 1ns/100ps
module swc_host_test;
    import swc_pkg::*;
    localparam int unsigned FALL_NS = 2000;
    logic        sys_clk;
    logic        rst_n;
    logic        cmd_valid;
    logic [2:0]  cmd_code;
    logic [7:0]  cmd_data;
    logic        ready_q;
    logic        done_q;
    logic        error_q;
    logic [7:0]  rd_data_q;
    logic        presence_q;
    logic        fast_q;
    logic [15:0] crc_q;
    logic        crc_good_q;
    logic        line_o_q;
    logic        line_oe_q;
    logic        present;
    logic        go_fast;
    logic        reply_en;
    logic        slow_reply;
    logic [7:0]  tx_byte;
    logic        dev_pull;
    logic        dev_od;
    logic [7:0]  rx_byte;
    int          rec_err;
    int          falls;
    longint      last_low;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          n_cyc;
    logic        saw_err;
    logic [15:0] exp_crc;
    wire         line = (line_oe_q ? line_o_q : 1'b1) & !dev_pull;

    swc_host #(.FALL_TIME_NS(FALL_NS)) swc_host_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .ready_q(ready_q), .done_q(done_q), .error_q(error_q),
        .rd_data_q(rd_data_q), .presence_q(presence_q), .fast_q(fast_q), .crc_q(crc_q),
        .crc_good_q(crc_good_q), .line_i(line), .line_o_q(line_o_q), .line_oe_q(line_oe_q)
    );
    swc_dev_model swc_dev_model_inst (
        .line(line), .present(present), .go_fast(go_fast), .reply_en(reply_en),
        .slow_reply(slow_reply), .tx_byte(tx_byte), .pull(dev_pull), .od(dev_od),
        .rx_byte(rx_byte), .rec_err(rec_err), .falls(falls), .last_low(last_low)
    );

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    task automatic conclude;
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        return c;
    endfunction

    // request held until an edge that sees ready_q high takes it
    task automatic do_cmd(input logic [2:0] code, input logic [7:0] data, input int max_cyc);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_data  <= data;
        do @(posedge sys_clk); while (ready_q !== 1'b1);
        cmd_valid <= 1'b0;
        n_cyc = 0;
        do begin
            @(negedge sys_clk);
            n_cyc++;
        end while (done_q !== 1'b1 && n_cyc < max_cyc);
        saw_err = error_q;
        check_val("command done", 16'h1, 16'(done_q));
        check_val("line released", 16'h1, 16'(line));
        check_val("drive level", 16'h0, 16'(line_o_q));
        check_val("ready at done", 16'h1, 16'(ready_q));
    endtask

    task automatic t_write(input logic [7:0] b);
        do_cmd(CMD_WRITE, b, fast_q ? 5000 : 24000);
        check_val("written byte", {8'h0, b}, {8'h0, rx_byte});
        check_val("write error", 16'h0, 16'(saw_err));
    endtask

    task automatic t_codes;
        logic [2:0] bad [2] = '{3'h0, 3'h7};
        foreach (bad[i]) begin
            do_cmd(bad[i], 8'h00, 20);
            check_val("unknown code error", 16'h1, 16'(saw_err));
            check_val("unknown code latency", 16'h1, 16'(n_cyc));
        end
    endtask

    task automatic t_absent;
        int f;
        @(posedge sys_clk);
        present <= 1'b0;
        go_fast <= 1'b1;
        do_cmd(CMD_SET_FAST, 8'h00, 20);
        check_val("fast flag", 16'h1, 16'(fast_q));
        check_val("fast latency", 16'h1, 16'(n_cyc));
        do_cmd(CMD_RESET, 8'h00, 5000);
        check_val("absent error", 16'h1, 16'(saw_err));
        check_val("absent presence", 16'h0, 16'(presence_q));
        f = falls;
        do_cmd(CMD_WRITE, 8'hff, 20);
        check_val("refused error", 16'h1, 16'(saw_err));
        check_val("refused line", 16'(f), 16'(falls));
    endtask

    task automatic t_fast_reset;
        @(posedge sys_clk);
        present    <= 1'b1;
        slow_reply <= 1'b1;
        do_cmd(CMD_RESET, 8'h00, 5000);
        check_val("fast presence", 16'h1, 16'(presence_q));
        check_val("fast reset error", 16'h0, 16'(saw_err));
        check_val("fast kept", 16'h1, 16'(dev_od));
        check_val("fast low", 16'h1,
                  16'(last_low >= FST_RSTL_NS + FALL_NS - TICK_NS && last_low <= 80000));
        check_val("fast high", 16'h1,
                  16'(n_cyc * CLK_NS >= FST_RSTL_NS + FST_RSTH_NS - TICK_NS));
    endtask

    task automatic t_crc;
        do_cmd(CMD_CRC_CLEAR, 8'h00, 20);
        check_val("crc cleared", CRC_INIT, crc_q);
        t_write(8'h5a);
        t_write(8'hc3);
        exp_crc = crc_add(crc_add(CRC_INIT, 8'h5a), 8'hc3);
        // crc takes the last bit one cycle after done
        @(negedge sys_clk);
        check_val("crc value", exp_crc, crc_q);
        t_write(~exp_crc[7:0]);
        t_write(~exp_crc[15:8]);
        @(negedge sys_clk);
        check_val("crc residue", CRC_RESIDUE, crc_q);
        check_val("crc good", 16'h1, 16'(crc_good_q));
        check_val("recovery", 16'h0, 16'(rec_err));
    endtask

    task automatic t_read;
        logic [7:0] vals [2] = '{8'h3c, 8'h81};
        foreach (vals[i]) begin
            @(posedge sys_clk);
            reply_en <= 1'b1;
            tx_byte  <= vals[i];
            do_cmd(CMD_READ, 8'h00, 5000);
            check_val("read byte", {8'h0, vals[i]}, {8'h0, rd_data_q});
        end
        @(posedge sys_clk);
        reply_en <= 1'b0;
        @(negedge sys_clk);
        exp_crc = crc_add(crc_add(CRC_RESIDUE, 8'h3c), 8'h81);
        check_val("read crc", exp_crc, crc_q);
        do_cmd(CMD_CRC_CLEAR, 8'h00, 20);
        @(negedge sys_clk);
        check_val("crc cleared after read", CRC_INIT, crc_q);
    endtask

    task automatic t_std;
        @(posedge sys_clk);
        slow_reply <= 1'b0;
        do_cmd(CMD_RESET_STD, 8'h00, 40000);
        check_val("standard flag", 16'h0, 16'(fast_q));
        check_val("device speed", 16'h0, 16'(dev_od));
        check_val("std presence", 16'h1, 16'(presence_q));
        check_val("std low", 16'h1, 16'(last_low >= STD_RSTL_NS + FALL_NS - TICK_NS));
        check_val("std high", 16'h1,
                  16'(n_cyc * CLK_NS >= STD_RSTL_NS + STD_RSTH_NS - TICK_NS));
        t_write(8'h96);
        check_val("std recovery", 16'h0, 16'(rec_err));
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #2600000;
        miscompares++;
        conclude();
    end

    initial begin
        rst_n      = 1'b0;
        cmd_valid  = 1'b0;
        cmd_code   = 3'h0;
        cmd_data   = 8'h00;
        present    = 1'b0;
        go_fast    = 1'b0;
        reply_en   = 1'b0;
        slow_reply = 1'b0;
        tx_byte    = 8'h00;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check_val("ready after reset", 16'h1, 16'(ready_q));
        check_val("speed after reset", 16'h0, 16'(fast_q));
        t_codes();
        t_absent();
        t_fast_reset();
        t_crc();
        t_read();
        t_std();
        conclude();
    end
endmodule
